// ===== src/tgss_top.sv
// Purpose: Station address/rate setup and global status word sharing
// Assumes: Link framing outside; tokens arrive as one-cycle pulses
// Notes:   Tokens and housekeeping strobes come from the link layer
// Behaviour
// - Software station address only 0 to 77 octal
// - Station addresses unique on one link
// - Fixed channel takes address, rate from switches
// - Three software rates: 57.6, 115.2, 230.4 kbps
// - Diagnostic area of forty words when file valid
// - Status area sized sixty-four words at reset, one to sixty-four by configure
// - Entering program mode clears whole status area
// - One sixteen-bit word per station address
// - Token pass broadcasts own-address status word
// - Seen token stored at sender's slot only if sender address is below status area size
// - Slot index is the octal address value
// - Received words applied during housekeeping only
// - Any message write to status area faults
// - Hold decimal link identifier when bridged
// - Same rate everywhere, at most sixty-four stations
`timescale 1ns/1ps
`default_nettype none
module tgss_top
   import tgss_pkg::*;
#(
   parameter int AW = TGSS_ADDR_W,
   parameter int DW = TGSS_WORD_W
) (
   input  wire logic          MCLK_I,
   input  wire logic          RST_I,
   input  wire logic          FIXED_FIRST_CHANNEL_I,
   input  wire logic [AW-1:0] ADDRESS_RATE_SWITCH_ADDR_I,
   input  wire logic [1:0]    ADDRESS_RATE_SWITCH_RATE_I,
   input  wire logic          CFG_WR_I,
   input  wire logic [AW-1:0] CFG_ADDR_I,
   input  wire logic [1:0]    CFG_RATE_I,
   input  wire logic [15:0]   CFG_LINK_ID_I,
   input  wire logic [9:0]    CFG_DIAG_FILE_I,
   input  wire logic [6:0]    CFG_GSF_SIZE_I,
   input  wire logic          RUN_MODE_I,
   input  wire logic          HOUSEKEEP_I,
   input  wire logic          TOKEN_RX_I,
   input  wire logic [AW-1:0] TOKEN_SRC_I,
   input  wire logic [DW-1:0] TOKEN_DATA_I,
   input  wire logic          TOKEN_PASS_REQ_I,
   input  wire logic          MSG_WR_GSF_I,
   input  wire logic          FAULT_CLR_I,
   output logic      [AW-1:0] STATION_ADDR_O,
   output logic      [1:0]    LINE_RATE_O,
   output logic      [15:0]   LINK_ID_O,
   output logic               DIAG_EN_O,
   output logic      [5:0]    DIAG_WORDS_O,
   output logic      [6:0]    GSF_SIZE_O,
   output logic               CFG_ERR_O,
   output logic               TOKEN_TX_O,
   output logic      [DW-1:0] TOKEN_TX_DATA_O,
   output logic               FAULT_O,
   output logic               BUSY_O
);
   // Switch pins are asynchronous: two stages each
   logic [AW-1:0] sw_addr_s1_q, sw_addr_s2_q;
   logic [1:0]    sw_rate_s1_q, sw_rate_s2_q;
   logic          fixed_s1_q, fixed_s2_q;

   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         sw_addr_s1_q <= '0;
         sw_addr_s2_q <= '0;
         sw_rate_s1_q <= '0;
         sw_rate_s2_q <= '0;
         fixed_s1_q   <= 1'b0;
         fixed_s2_q   <= 1'b0;
      end else begin
         sw_addr_s1_q <= ADDRESS_RATE_SWITCH_ADDR_I;
         sw_addr_s2_q <= sw_addr_s1_q;
         sw_rate_s1_q <= ADDRESS_RATE_SWITCH_RATE_I;
         sw_rate_s2_q <= sw_rate_s1_q;
         fixed_s1_q   <= FIXED_FIRST_CHANNEL_I;
         fixed_s2_q   <= fixed_s1_q;
      end
   end

   function automatic logic rate_ok(input logic [1:0] r);
      rate_ok = (r == TGSS_RATE_57K6) || (r == TGSS_RATE_115K2) || (r == TGSS_RATE_230K4);
   endfunction : rate_ok

   // Configuration registers
   logic [AW-1:0] sw_addr_q;
   logic [1:0]    sw_rate_q;
   logic [15:0]   link_id_q;
   logic          diag_en_q;
   logic [6:0]    gsf_size_q;
   logic [5:0]    diag_words_q;
   logic          cfg_err_q;
   logic [AW-1:0] station_addr_q;
   logic [1:0]    line_rate_q;

   // 6-bit field already spans 0..77 octal; kept explicit if the width grows
   wire cfg_addr_ok = ({1'b0, CFG_ADDR_I} < 7'(TGSS_STATIONS));
   wire cfg_rate_ok = rate_ok(CFG_RATE_I);
   wire diag_ok     = (CFG_DIAG_FILE_I >= TGSS_FILE_MIN) &&
                      (CFG_DIAG_FILE_I <= TGSS_FILE_MAX);
   wire [5:0] diag_words_d = diag_ok ? 6'(TGSS_DIAG_WORDS) : 6'h00;
   wire gsf_size_ok = (CFG_GSF_SIZE_I != 7'h00) && (CFG_GSF_SIZE_I <= TGSS_GSF_DEFAULT);
   wire cfg_good    = cfg_addr_ok && cfg_rate_ok && gsf_size_ok;

   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         sw_addr_q  <= TGSS_ADDR_RST;
         sw_rate_q  <= TGSS_RATE_57K6;
         link_id_q  <= TGSS_LINK_ID_RST;
         diag_en_q  <= 1'b0;
         diag_words_q <= 6'h00;
         gsf_size_q <= TGSS_GSF_DEFAULT;
         cfg_err_q  <= 1'b0;
      end else if (CFG_WR_I) begin
         cfg_err_q <= !cfg_good;
         // Bad writes leave the old settings in place
         if (cfg_good) begin
            sw_addr_q  <= CFG_ADDR_I;
            sw_rate_q  <= CFG_RATE_I;
            link_id_q  <= CFG_LINK_ID_I;
            diag_en_q  <= diag_ok;
            diag_words_q <= diag_words_d;
            gsf_size_q <= CFG_GSF_SIZE_I;
         end
      end
   end

   // Fixed channel ignores software address and rate
   wire [AW-1:0] addr_d = fixed_s2_q ? sw_addr_s2_q : sw_addr_q;
   wire [1:0]    rate_d = fixed_s2_q ? sw_rate_s2_q : sw_rate_q;

   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         station_addr_q <= TGSS_ADDR_RST;
         line_rate_q    <= TGSS_RATE_57K6;
      end else begin
         // One own address per channel; uniqueness is the installer's job
         station_addr_q <= addr_d;
         line_rate_q    <= rate_d;
      end
   end

   // Pending receive buffer, one entry per station; applied in housekeeping
   logic [AW-1:0] src_oct_q;
   logic [TGSS_STATIONS-1:0] pend_q;
   logic [DW-1:0] pend_data_q [TGSS_STATIONS];
   wire  src_in_range = {1'b0, TOKEN_SRC_I} < gsf_size_q;
   wire  rx_take      = TOKEN_RX_I && src_in_range;

   // Scan state machine
   tgss_state_t   state_q, state_d;
   logic [AW-1:0] idx_q;
   logic          run_q;
   logic          fault_q;
   logic          tx_pend_q;
   logic          tx_rd_q;
   logic          token_tx_q;
   logic [DW-1:0] tx_data_q;
   logic          busy_q;

   wire enter_prog = run_q && !RUN_MODE_I;
   wire idx_last   = (idx_q == AW'(TGSS_STATIONS - 1));

   always_comb begin
      state_d = state_q;
      case (state_q)
         TGSS_IDLE: begin
            if (enter_prog) begin
               state_d = TGSS_CLEAR;
            end else if (tx_pend_q) begin
               state_d = TGSS_SEND;
            end else if (HOUSEKEEP_I && (pend_q != '0)) begin
               state_d = TGSS_APPLY;
            end
         end
         TGSS_APPLY: begin
            if (enter_prog) begin
               state_d = TGSS_CLEAR;
            end else if (idx_last) begin
               state_d = TGSS_IDLE;
            end
         end
         TGSS_CLEAR: begin
            if (idx_last) begin
               state_d = TGSS_IDLE;
            end
         end
         TGSS_SEND: begin
            // A mode change seen here would be lost by the time IDLE looks
            if (enter_prog) begin
               state_d = TGSS_CLEAR;
            end else begin
               state_d = TGSS_IDLE;
            end
         end
         default: state_d = TGSS_IDLE;
      endcase
   end

   wire mem_we_apply = (state_q == TGSS_APPLY) && pend_q[idx_q];
   wire mem_we_clear = (state_q == TGSS_CLEAR);
   wire mem_we       = mem_we_apply || mem_we_clear;
   // Slot index equals the binary value of the octal address
   wire [AW-1:0] mem_waddr = idx_q;
   wire [DW-1:0] mem_wdata = mem_we_clear ? '0 : pend_data_q[idx_q];
   wire          send_rd   = (state_q == TGSS_SEND);
   wire [DW-1:0] mem_rdata;

   tgss_mem #(
      .DEPTH (TGSS_STATIONS),
      .AW    (AW),
      .DW    (DW)
   ) u_mem (
      .clk_i   (MCLK_I),
      .we_i    (mem_we),
      .waddr_i (mem_waddr),
      .wdata_i (mem_wdata),
      .raddr_i (station_addr_q),
      .rdata_o (mem_rdata)
   );

   always_ff @(posedge MCLK_I) begin
      if (rx_take) begin
         pend_data_q[TOKEN_SRC_I] <= TOKEN_DATA_I;
      end
   end

   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_q    <= TGSS_IDLE;
         idx_q      <= '0;
         run_q      <= 1'b0;
         pend_q     <= '0;
         fault_q    <= 1'b0;
         tx_pend_q  <= 1'b0;
         tx_rd_q    <= 1'b0;
         token_tx_q <= 1'b0;
         tx_data_q  <= '0;
         busy_q     <= 1'b0;
      end else begin
         state_q <= state_d;
         run_q   <= RUN_MODE_I;
         busy_q  <= (state_d != TGSS_IDLE);
         idx_q   <= (state_d != state_q) ? '0 : idx_q + AW'(1);
         // Clearing flushes waiting words too, so stale data never lands
         for (int i = 0; i < TGSS_STATIONS; i++) begin
            if (rx_take && (TOKEN_SRC_I == AW'(i))) begin
               pend_q[i] <= 1'b1;
            end else if (mem_we_clear || (mem_we_apply && (idx_q == AW'(i)))) begin
               pend_q[i] <= 1'b0;
            end
         end
         // Fault is sticky; a new violation wins over the clear
         if (MSG_WR_GSF_I) begin
            fault_q <= 1'b1;
         end else if (FAULT_CLR_I) begin
            fault_q <= 1'b0;
         end
         if (TOKEN_PASS_REQ_I) begin
            tx_pend_q <= 1'b1;
         end else if (send_rd) begin
            tx_pend_q <= 1'b0;
         end
         tx_rd_q    <= send_rd;
         token_tx_q <= tx_rd_q;
         if (tx_rd_q) begin
            tx_data_q <= mem_rdata;
         end
      end
   end

   assign STATION_ADDR_O  = station_addr_q;
   assign LINE_RATE_O     = line_rate_q;
   assign LINK_ID_O       = link_id_q;
   assign DIAG_EN_O       = diag_en_q;
   assign DIAG_WORDS_O    = diag_words_q;
   assign GSF_SIZE_O      = gsf_size_q;
   assign CFG_ERR_O       = cfg_err_q;
   assign TOKEN_TX_O      = token_tx_q;
   assign TOKEN_TX_DATA_O = tx_data_q;
   assign FAULT_O         = fault_q;
   assign BUSY_O          = busy_q;
endmodule : tgss_top
`default_nettype wire

// ===== src/tgss_pkg.sv
// Purpose: Shared constants for the token global status share block
// Assumes: 64 stations, 16-bit status words
// Notes:   Rate codes select one of three line rates
package tgss_pkg;
   localparam int          TGSS_STATIONS     = 64;
   localparam int          TGSS_ADDR_W       = 6;
   localparam int          TGSS_WORD_W       = 16;
   localparam int          TGSS_DIAG_WORDS   = 40;
   localparam int          TGSS_FILE_W       = 10;
   localparam logic [9:0]  TGSS_FILE_MIN     = 10'h00a;
   localparam logic [9:0]  TGSS_FILE_MAX     = 10'h3e7;
   localparam logic [6:0]  TGSS_GSF_DEFAULT  = 7'h40;
   localparam logic [1:0]  TGSS_RATE_57K6    = 2'h0;
   localparam logic [1:0]  TGSS_RATE_115K2   = 2'h1;
   localparam logic [1:0]  TGSS_RATE_230K4   = 2'h2;
   localparam logic [15:0] TGSS_LINK_ID_RST  = 16'h0000;
   localparam logic [5:0]  TGSS_ADDR_RST     = 6'h00;

   typedef enum logic [3:0] {
      TGSS_IDLE  = 4'h1,
      TGSS_APPLY = 4'h2,
      TGSS_CLEAR = 4'h4,
      TGSS_SEND  = 4'h8
   } tgss_state_t;
endpackage : tgss_pkg

// ===== src/tgss_mem.sv
// Purpose: Status word memory, one word per station
// Assumes: Single write port, registered read
// Notes:   Read data appear one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module tgss_mem #(
   parameter int DEPTH = 64,
   parameter int AW    = 6,
   parameter int DW    = 16
) (
   input  wire logic          clk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [DW-1:0] rdata_o
);
   logic [DW-1:0] mem_q [DEPTH];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_q[raddr_i];
   end
endmodule : tgss_mem
`default_nettype wire

// ===== test/tgss_far_station.sv
// Purpose: Far station on the link, one token per request
// Assumes: Request is a one-cycle pulse
// Notes:   Lines invert between tokens
`timescale 1ns/1ps
`default_nettype none
module tgss_far_station (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        go_i,
   input  wire logic [5:0]  addr_i,
   input  wire logic [15:0] word_i,
   output logic             tok_o,
   output logic      [5:0]  src_o,
   output logic      [15:0] data_o
);
   // No stale value between tokens, so a late sample shows up
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         {tok_o, src_o, data_o} <= '0;
      end else begin
         tok_o  <= go_i;
         src_o  <= go_i ? addr_i : ~src_o;
         data_o <= go_i ? word_i : ~data_o;
      end
   end
endmodule : tgss_far_station
`default_nettype wire

// ===== test/tgss_monitor.sv
// Purpose: Port checker for the status share block
// Assumes: One clock, async active-high reset
// Notes:   Bound from the bench
`timescale 1ns/1ps
`default_nettype none
module tgss_monitor #(
   parameter int AW = 6
) (
   input wire logic          MCLK_I,
   input wire logic          RST_I,
   input wire logic          FIXED_FIRST_CHANNEL_I,
   input wire logic [AW-1:0] ADDRESS_RATE_SWITCH_ADDR_I,
   input wire logic          CFG_WR_I,
   input wire logic [1:0]    CFG_RATE_I,
   input wire logic          RUN_MODE_I,
   input wire logic          MSG_WR_GSF_I,
   input wire logic          FAULT_CLR_I,
   input wire logic [AW-1:0] STATION_ADDR_O,
   input wire logic [1:0]    LINE_RATE_O,
   input wire logic [6:0]    GSF_SIZE_O,
   input wire logic          CFG_ERR_O,
   input wire logic          TOKEN_TX_O,
   input wire logic          FAULT_O,
   input wire logic          BUSY_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);
   property p_set; MSG_WR_GSF_I |=> FAULT_O; endproperty
   a_set: assert property (p_set) else $error("fault not set");
   property p_keep; FAULT_O && !FAULT_CLR_I |=> FAULT_O; endproperty
   a_keep: assert property (p_keep) else $error("fault lost");
   property p_fclr; FAULT_CLR_I && !MSG_WR_GSF_I |=> !FAULT_O; endproperty
   a_fclr: assert property (p_fclr) else $error("fault kept");
   property p_txp; TOKEN_TX_O |=> !TOKEN_TX_O; endproperty
   a_txp: assert property (p_txp) else $error("long token");
   property p_clr; $fell(RUN_MODE_I) |-> ##[1:3] BUSY_O [*8]; endproperty
   a_clr: assert property (p_clr) else $error("no clear");
   property p_rej; CFG_WR_I && CFG_RATE_I == 2'h3 |=> CFG_ERR_O; endproperty
   a_rej: assert property (p_rej) else $error("bad rate taken");
   property p_size; GSF_SIZE_O != 7'h00 && GSF_SIZE_O <= 7'h40; endproperty
   a_size: assert property (p_size) else $error("size range");
   property p_rate; LINE_RATE_O != 2'h3; endproperty
   a_rate: assert property (p_rate) else $error("rate code");
   property p_sw; (FIXED_FIRST_CHANNEL_I && $stable(ADDRESS_RATE_SWITCH_ADDR_I)) [*6]
      |-> STATION_ADDR_O == ADDRESS_RATE_SWITCH_ADDR_I; endproperty
   a_sw: assert property (p_sw) else $error("switch addr");
endmodule : tgss_monitor
`default_nettype wire

// ===== test/tb.sv
// Purpose: Self-checking bench for the status share block
// Assumes: Slots read back through token pass data
// Notes:   Far station model drives token inputs
`timescale 1ns/1ps
`default_nettype none
module tb
   import tgss_pkg::*;
   ;
   localparam logic [9:0] FT [4] = '{10'h009, 10'h00a, 10'h3e7, 10'h3e8};
   logic        clk, rst, fix, cwr, run, hk, go, pr, mw, fc, tok, de, err, tx, flt, bsy;
   logic [5:0]  swa, ca, fa, sa, a, tsrc, dw;
   logic [1:0]  swr, cr, lr;
   logic [9:0]  cf;
   logic [6:0]  cs, gs;
   logic [15:0] lid, fw, w, lo, txd, tdat, exp_q [64];
   logic [31:0] rnd = 32'hbe43cdd7;
   int          n_mismatch = 0, check_count = 0, cyc = 0, i;
   tgss_top tgss_top_i (.MCLK_I(clk), .RST_I(rst), .FIXED_FIRST_CHANNEL_I(fix),
      .ADDRESS_RATE_SWITCH_ADDR_I(swa), .ADDRESS_RATE_SWITCH_RATE_I(swr), .CFG_WR_I(cwr),
      .CFG_ADDR_I(ca), .CFG_RATE_I(cr), .CFG_LINK_ID_I(lid), .CFG_DIAG_FILE_I(cf),
      .CFG_GSF_SIZE_I(cs), .RUN_MODE_I(run), .HOUSEKEEP_I(hk), .TOKEN_RX_I(tok),
      .TOKEN_SRC_I(tsrc), .TOKEN_DATA_I(tdat), .TOKEN_PASS_REQ_I(pr), .MSG_WR_GSF_I(mw),
      .FAULT_CLR_I(fc), .STATION_ADDR_O(sa), .LINE_RATE_O(lr), .LINK_ID_O(lo),
      .DIAG_EN_O(de), .DIAG_WORDS_O(dw), .GSF_SIZE_O(gs), .CFG_ERR_O(err),
      .TOKEN_TX_O(tx), .TOKEN_TX_DATA_O(txd), .FAULT_O(flt), .BUSY_O(bsy));
   tgss_far_station tgss_far_station_i (.clk_i(clk), .rst_i(rst), .go_i(go), .addr_i(fa),
      .word_i(fw), .tok_o(tok), .src_o(tsrc), .data_o(tdat));
   function automatic logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : nx
   function automatic logic [5:0] f_diag(input logic [9:0] f);
      return (f >= TGSS_FILE_MIN && f <= TGSS_FILE_MAX) ? 6'(TGSS_DIAG_WORDS) : 6'h00;
   endfunction : f_diag
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic idle();
      int j;
      j = 0;
      tick();
      while (bsy !== 1'h0 && j < 100) begin
         tick();
         j++;
      end
   endtask : idle
   task automatic cfg(input logic [5:0] ad, input logic [1:0] r, input logic [9:0] f,
                      input logic [6:0] s);
      logic e;
      e = r == 2'h3 || s == 7'h00 || s > 7'h40;
      rnd = nx(rnd);
      {ca, cr, cf, cs, lid, cwr} = {ad, r, f, s, rnd[15:0], 1'h1};
      tick();
      cwr = 1'h0;
      repeat (2) tick();
      chk(16'(err), 16'(e));
      if (!e) begin
         chk(lo, lid);
         chk(16'(dw), 16'(f_diag(f)));
         chk(16'(de), 16'(f_diag(f) != 6'h00));
         chk(16'(gs), 16'(s));
         chk(16'(sa), fix ? 16'(swa) : 16'(ad));
         chk(16'(lr), fix ? 16'(swr) : 16'(r));
      end
   endtask : cfg
   task automatic rx(input logic [5:0] s, input logic [15:0] d);
      {fa, fw, go} = {s, d, 1'h1};
      tick();
      go = 1'h0;
      tick();
   endtask : rx
   task automatic hkw();
      hk = 1'h1;
      tick();
      hk = 1'h0;
      idle();
   endtask : hkw
   task automatic send(input logic [5:0] s);
      int j;
      cfg(s, 2'h1, 10'h00a, 7'h40);
      pr = 1'h1;
      tick();
      pr = 1'h0;
      for (j = 0; j < 20 && tx !== 1'h1; j++) tick();
      chk(16'(tx), 16'h0001);
      chk(txd, exp_q[s]);
      idle();
   endtask : send
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      {rst, fix, cwr, run, hk, go, pr, mw, fc} = 9'h100;
      {swa, swr, ca, cr, cf, lid, fa, fw} = '0;
      cs = 7'h40;
      for (i = 0; i < 64; i++) exp_q[i] = 16'h0000;
      repeat (4) tick();
      {rst, run} = 2'h1;
      tick();
      run = 1'h0;
      idle();
      run = 1'h1;
      for (i = 0; i < 4; i++) cfg(6'(i * 13), 2'(i), FT[i], 7'h40);
      cfg(6'h3f, 2'h0, 10'h00a, 7'h00);
      cfg(6'h3f, 2'h2, 10'h3e7, 7'h41);
      {fix, swa, swr} = {1'h1, 6'h2a, 2'h2};
      repeat (6) tick();
      cfg(6'h05, 2'h0, 10'h00a, 7'h40);
      fix = 1'h0;
      repeat (4) tick();
      $display("test config done");
      w = rnd[31:16];
      rx(6'h18, w); // Octal 30 lands in word 24
      send(6'h18);
      hkw();
      exp_q[24] = w;
      send(6'h18);
      cfg(6'h00, 2'h0, 10'h00a, 7'h14);
      rx(6'h13, ~w);
      rx(6'h14, 16'h0f0f);
      hkw();
      exp_q[19] = ~w;
      send(6'h13);
      send(6'h14);
      for (i = 0; i < 6; i++) begin
         rnd = nx(rnd);
         a = rnd[5:0];
         rx(a, rnd[31:16]);
         rx(a ^ 6'h01, ~rnd[31:16]);
         hkw();
         exp_q[a] = rnd[31:16];
         exp_q[a ^ 6'h01] = ~rnd[31:16];
         send(a);
         send(a ^ 6'h01);
      end
      $display("test share done");
      {mw, fc} = 2'h3;
      tick();
      {mw, fc} = 2'h0;
      tick();
      chk(16'(flt), 16'h0001);
      fc = 1'h1;
      tick();
      fc = 1'h0;
      tick();
      chk(16'(flt), 16'h0000);
      run = 1'h0;
      tick();
      idle();
      run = 1'h1;
      for (i = 0; i < 64; i++) exp_q[i] = 16'h0000;
      send(a);
      send(6'h18);
      $display("test fault and clear done");
      final_report();
   end
endmodule : tb
bind tgss_top tgss_monitor #(.AW(AW)) tgss_monitor_i (.MCLK_I, .RST_I, .FIXED_FIRST_CHANNEL_I,
   .ADDRESS_RATE_SWITCH_ADDR_I, .CFG_WR_I, .CFG_RATE_I, .RUN_MODE_I, .MSG_WR_GSF_I,
   .FAULT_CLR_I, .STATION_ADDR_O, .LINE_RATE_O, .GSF_SIZE_O, .CFG_ERR_O, .TOKEN_TX_O,
   .FAULT_O, .BUSY_O);
`default_nettype wire
